// ===== verilog/dac_update_pkg.sv
package dac_update_pkg;
    // frame layout
    localparam int FRAME_W = 16;
    localparam int CNT_W = 4;
    localparam logic [3:0] CNT_LAST = 4'hF;
    localparam int TYPE_BIT = 15;
    localparam int MODE_HI = 14;
    localparam int MODE_LO = 13;
    localparam int ADDR_HI = 14;
    localparam int ADDR_LO = 12;
    localparam int DATA_HI = 11;
    localparam int FULL_RESET_BIT = 12;
    localparam int OPT_HI = 1;
    localparam int OPT_LO = 0;
    localparam int CFG_HI = 5;
    localparam int PD_HI = 7;
    // channel count and code width
    localparam int CH_N = 8;
    localparam int DATA_W = 12;

    typedef enum logic [1:0] {
        mode_refgain = 2'h0,
        mode_strobe = 2'h1,
        mode_pwrdn = 2'h2,
        mode_reset = 2'h3
    } mode_type;

    typedef enum logic [1:0] {
        opt_continuous = 2'h0,
        opt_latched = 2'h1,
        opt_single = 2'h2,
        opt_reserved = 2'h3
    } strobe_opt_type;

    // index 1 is the upper quad, index 0 the lower quad
    typedef struct packed {
        logic [1:0] gain;
        logic [1:0] buffered;
        logic [1:0] supply;
    } ref_cfg_type;

    typedef struct packed {
        logic sclk;
        logic sync_n;
        logic din;
        logic strobe_n;
    } serial_pins_type;

    typedef struct packed {
        logic done;
        logic [FRAME_W-1:0] word;
    } frame_type;

    // power-on values
    localparam strobe_opt_type OPT_RESET = opt_latched;
    localparam ref_cfg_type REF_CFG_RESET = 6'h00;
    localparam logic [7:0] PWRDN_RESET = 8'h00;
    localparam logic [31:0] CTRL_RESET = 32'h00000001;

    // register map, byte addresses
    localparam int APB_AW = 8;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [2:0] PAGE_DAC = 3'h1;
    localparam logic [2:0] PAGE_INPUT = 3'h2;
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int ST_OPT_LO = 0;
    localparam int ST_ACT_LO = 2;
    localparam int ST_PEND_LO = 8;
    localparam int ST_CFG_DIRTY = 14;
    localparam int ST_IFACE_ON = 15;
    localparam int ST_PWRDN_LO = 16;
    localparam int ST_DIRTY_LO = 24;
endpackage : dac_update_pkg

// ===== verilog/frame_receiver.sv
// pin synchroniser, frame select gating and 16-bit shifter
module frame_receiver (
    input wire logic clk,
    input wire logic nrst,
    input wire dac_update_pkg::serial_pins_type pins,
    output dac_update_pkg::frame_type frame,
    output logic strobe_low,
    output logic iface_on
);
    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_shift = 2'b01,
        st_wait = 2'b11
    } rx_state_type;

    dac_update_pkg::serial_pins_type meta_ff, sync_ff, prev_ff;
    rx_state_type state_ff;
    logic [dac_update_pkg::CNT_W-1:0] cnt_ff;
    logic [dac_update_pkg::FRAME_W-1:0] shift_ff;
    dac_update_pkg::frame_type frame_ff;
    logic strobe_low_ff, iface_on_ff;
    logic sclk_fall, sel_fall, sel_rise, last_bit;

    // two stages before any logic looks at a pin
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meta_ff <= 4'hF;
            sync_ff <= 4'hF;
            prev_ff <= 4'hF;
        end else begin
            meta_ff <= pins;
            sync_ff <= meta_ff;
            prev_ff <= sync_ff;
        end
    end

    // edges of the sampled link clock and frame select
    assign sclk_fall = prev_ff.sclk & ~sync_ff.sclk;
    assign sel_fall = prev_ff.sync_n & ~sync_ff.sync_n;
    assign sel_rise = ~prev_ff.sync_n & sync_ff.sync_n;
    assign last_bit = (state_ff == st_shift) && sclk_fall && (cnt_ff == dac_update_pkg::CNT_LAST);

    // frame sequence; edges past the sixteenth are ignored
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_ff <= st_idle;
        end else begin
            case (state_ff)
                st_idle: if (sel_fall) state_ff <= st_shift;
                st_shift: begin
                    if (sel_rise) begin
                        state_ff <= st_idle;
                    end else if (last_bit) begin
                        state_ff <= st_wait;
                    end
                end
                st_wait: if (sel_rise) state_ff <= st_idle;
                default: state_ff <= st_idle;
            endcase
        end
    end

    // shifting only while the front end is on, msb first
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_ff <= '0;
            shift_ff <= '0;
        end else if (state_ff == st_idle) begin
            cnt_ff <= '0;
        end else if (state_ff == st_shift && sclk_fall) begin
            cnt_ff <= cnt_ff + 4'h1;
            shift_ff <= {shift_ff[dac_update_pkg::FRAME_W-2:0], sync_ff.din};
        end
    end

    // completed word; an abort in the same sample wins
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            frame_ff <= '0;
        end else begin
            frame_ff.done <= last_bit & ~sel_rise;
            if (last_bit) begin
                frame_ff.word <= {shift_ff[dac_update_pkg::FRAME_W-2:0], sync_ff.din};
            end
        end
    end

    // strobe pin level and front-end status
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            strobe_low_ff <= 1'b0;
            iface_on_ff <= 1'b0;
        end else begin
            strobe_low_ff <= ~sync_ff.strobe_n;
            iface_on_ff <= (state_ff != st_idle);
        end
    end

    assign frame = frame_ff;
    assign strobe_low = strobe_low_ff;
    assign iface_on = iface_on_ff;

    abort_no_frame_a: assert property (
        @(posedge clk) disable iff (!nrst)
        (state_ff == st_shift && sel_rise) |=> !frame_ff.done
    ) else $error("aborted frame produced a word");

    frame_after_last_a: assert property (
        @(posedge clk) disable iff (!nrst)
        frame_ff.done |-> $past(cnt_ff) == dac_update_pkg::CNT_LAST && state_ff == st_wait
    ) else $error("word completed without sixteen clock edges");

    idle_gated_a: assert property (
        @(posedge clk) disable iff (!nrst)
        (state_ff == st_idle && !sel_fall) |=> $stable(shift_ff) && state_ff == st_idle
    ) else $error("shifter moved while frame select was high");
endmodule : frame_receiver

// ===== verilog/dac_update_ctrl.sv
// Overview of operation
// - control mode 01 sets strobe option
// - option 00 keeps strobe always asserted
// - latched option 01 after power-on
// - option 10 gives one strobe pulse
// - control mode 10 is power-down command
// - set bits power channels down
// - data reset clears input and dac registers
// - full reset also restores strobe option, reference and power-down
// - front end on only inside frame
// - reference settings double-buffered like data
// - synchronous update right after sixteenth edge
// - strobe pin held low copies input registers
// - valid write loads addressed input register
// - latched option and high pin hold
// - option 00 or low pin transparent
// - copy only channels written since update
// - data sampled on falling clock edges
// - early select rise aborts frame
// - bit 15 selects data or control
// - bits 14 to 12 address channel
// - supply reference overrides buffer and gain
//
// The address map and register access over APB were chosen for this implementation.
module dac_update_ctrl #(
    parameter int CH_N = dac_update_pkg::CH_N,
    parameter int DATA_W = dac_update_pkg::DATA_W
) (
    input wire logic clk,
    input wire logic nrst,
    input wire dac_update_pkg::serial_pins_type pins,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [dac_update_pkg::APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [CH_N-1:0][DATA_W-1:0] dac_code,
    output dac_update_pkg::ref_cfg_type ref_cfg,
    output logic [CH_N-1:0] pwrdn,
    output logic iface_on
);
    dac_update_pkg::frame_type frame;
    logic strobe_low;
    logic [15:0] word;
    logic fr_ok, is_ctrl, do_strobe, do_pd, do_reset, do_full, do_refgain, load_now;
    dac_update_pkg::mode_type mode;
    dac_update_pkg::strobe_opt_type new_opt;
    dac_update_pkg::strobe_opt_type opt_ff;
    dac_update_pkg::ref_cfg_type pend_cfg_ff, act_cfg_ff, eff_cfg;
    logic single_ff, cfg_dirty_ff;
    logic [CH_N-1:0] pwrdn_ff;
    logic [DATA_W-1:0] in_ff [CH_N];
    logic [DATA_W-1:0] dac_ff [CH_N];
    logic dirty_ff [CH_N];
    logic [CH_N-1:0] dirty_vec;
    logic [31:0] ctrl_ff, prdata_ff, rd_data;
    logic pready_ff, pslverr_ff, rd_hit, apb_take, apb_done;

    frame_receiver u_rx (
        .clk(clk),
        .nrst(nrst),
        .pins(pins),
        .frame(frame),
        .strobe_low(strobe_low),
        .iface_on(iface_on)
    );

    // frame decode; frames are dropped while software disables the link
    assign word = frame.word;
    assign fr_ok = frame.done & ctrl_ff[dac_update_pkg::CTRL_ENABLE_BIT];
    assign is_ctrl = word[dac_update_pkg::TYPE_BIT];
    assign mode = dac_update_pkg::mode_type'(word[dac_update_pkg::MODE_HI:dac_update_pkg::MODE_LO]);
    assign new_opt = dac_update_pkg::strobe_opt_type'(word[dac_update_pkg::OPT_HI:dac_update_pkg::OPT_LO]);
    assign do_refgain = fr_ok & is_ctrl & (mode == dac_update_pkg::mode_refgain);
    assign do_strobe = fr_ok & is_ctrl & (mode == dac_update_pkg::mode_strobe) &
                       (new_opt != dac_update_pkg::opt_reserved);
    assign do_pd = fr_ok & is_ctrl & (mode == dac_update_pkg::mode_pwrdn);
    assign do_reset = fr_ok & is_ctrl & (mode == dac_update_pkg::mode_reset);
    assign do_full = do_reset & word[dac_update_pkg::FULL_RESET_BIT];

    // the strobe: continuous option, a low pin, or the one-shot pulse
    assign load_now = (opt_ff == dac_update_pkg::opt_continuous) | strobe_low | single_ff;

    // supply reference forces unbuffered, unity gain
    always_comb begin
        eff_cfg = pend_cfg_ff;
        eff_cfg.gain = pend_cfg_ff.gain & ~pend_cfg_ff.supply;
        eff_cfg.buffered = pend_cfg_ff.buffered & ~pend_cfg_ff.supply;
    end

    // strobe option and single-update pulse
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            opt_ff <= dac_update_pkg::OPT_RESET;
            single_ff <= 1'b0;
        end else if (do_full) begin
            opt_ff <= dac_update_pkg::OPT_RESET;
            single_ff <= 1'b0;
        end else if (do_strobe) begin
            single_ff <= (new_opt == dac_update_pkg::opt_single);
            // a single update behaves as latched once its pulse is out
            opt_ff <= (new_opt == dac_update_pkg::opt_single) ? dac_update_pkg::opt_latched : new_opt;
        end else begin
            single_ff <= 1'b0;
        end
    end

    // pending and active reference settings
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pend_cfg_ff <= dac_update_pkg::REF_CFG_RESET;
            act_cfg_ff <= dac_update_pkg::REF_CFG_RESET;
            cfg_dirty_ff <= 1'b0;
        end else if (do_full) begin
            pend_cfg_ff <= dac_update_pkg::REF_CFG_RESET;
            act_cfg_ff <= dac_update_pkg::REF_CFG_RESET;
            cfg_dirty_ff <= 1'b0;
        end else begin
            if (load_now && cfg_dirty_ff) begin
                act_cfg_ff <= eff_cfg;
            end
            if (do_refgain) begin
                pend_cfg_ff <= word[dac_update_pkg::CFG_HI:0];
            end
            // a new setting arriving with the transfer stays pending
            cfg_dirty_ff <= do_refgain | (cfg_dirty_ff & ~load_now);
        end
    end

    // per-channel power state
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pwrdn_ff <= dac_update_pkg::PWRDN_RESET;
        end else if (do_full) begin
            pwrdn_ff <= dac_update_pkg::PWRDN_RESET;
        end else if (do_pd) begin
            pwrdn_ff <= word[CH_N-1:0];
        end
    end

    // input and dac registers, one pair per channel
    for (genvar i = 0; i < CH_N; i++) begin : g_ch
        logic wr_ch;
        logic copy;
        assign wr_ch = fr_ok & ~is_ctrl &
                       (word[dac_update_pkg::ADDR_HI:dac_update_pkg::ADDR_LO] == 3'(i));
        assign copy = load_now & dirty_ff[i];
        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                in_ff[i] <= '0;
                dac_ff[i] <= '0;
                dirty_ff[i] <= 1'b0;
            end else if (do_reset) begin
                in_ff[i] <= '0;
                dac_ff[i] <= '0;
                dirty_ff[i] <= 1'b0;
            end else begin
                if (wr_ch) begin
                    in_ff[i] <= word[dac_update_pkg::DATA_HI -: DATA_W];
                end
                if (copy) begin
                    dac_ff[i] <= in_ff[i];
                end
                // a write in the copy cycle keeps the channel pending
                dirty_ff[i] <= wr_ch | (dirty_ff[i] & ~copy);
            end
        end
        assign dac_code[i] = dac_ff[i];
        assign dirty_vec[i] = dirty_ff[i];
    end

    // apb read decode; unaligned or unmapped addresses answer with an error
    always_comb begin
        rd_data = 32'h00000000;
        rd_hit = 1'b1;
        if (paddr[1:0] != 2'h0) begin
            rd_hit = 1'b0;
        end else if (paddr == dac_update_pkg::ADDR_CTRL) begin
            rd_data = ctrl_ff;
        end else if (paddr == dac_update_pkg::ADDR_STATUS) begin
            rd_data[dac_update_pkg::ST_OPT_LO +: 2] = opt_ff;
            rd_data[dac_update_pkg::ST_ACT_LO +: 6] = act_cfg_ff;
            rd_data[dac_update_pkg::ST_PEND_LO +: 6] = pend_cfg_ff;
            rd_data[dac_update_pkg::ST_CFG_DIRTY] = cfg_dirty_ff;
            rd_data[dac_update_pkg::ST_IFACE_ON] = iface_on;
            rd_data[dac_update_pkg::ST_PWRDN_LO +: CH_N] = pwrdn_ff;
            rd_data[dac_update_pkg::ST_DIRTY_LO +: CH_N] = dirty_vec;
        end else if (paddr[7:5] == dac_update_pkg::PAGE_DAC) begin
            rd_data[DATA_W-1:0] = dac_ff[paddr[4:2]];
        end else if (paddr[7:5] == dac_update_pkg::PAGE_INPUT) begin
            rd_data[DATA_W-1:0] = in_ff[paddr[4:2]];
        end else begin
            rd_hit = 1'b0;
        end
    end

    // one wait state: pready rises in the second access cycle
    assign apb_take = psel & penable & ~pready_ff;
    assign apb_done = psel & penable & pready_ff;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h00000000;
        end else begin
            pready_ff <= apb_take;
            pslverr_ff <= apb_take & ~rd_hit;
            prdata_ff <= (apb_take && !pwrite) ? rd_data : 32'h00000000;
        end
    end

    // control register written at the completing edge only
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_ff <= dac_update_pkg::CTRL_RESET;
        end else if (apb_done && pwrite && paddr == dac_update_pkg::ADDR_CTRL) begin
            ctrl_ff <= {31'h00000000, pwdata[dac_update_pkg::CTRL_ENABLE_BIT]};
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign ref_cfg = act_cfg_ff;
    assign pwrdn = pwrdn_ff;

    power_on_opt_a: assert property (
        @(posedge clk) disable iff (!nrst)
        $rose(nrst) |-> opt_ff == dac_update_pkg::opt_latched && !single_ff
    ) else $error("strobe option not latched after reset");

    reserved_ignored_a: assert property (
        @(posedge clk) disable iff (!nrst)
        (fr_ok && is_ctrl && mode == dac_update_pkg::mode_strobe &&
         new_opt == dac_update_pkg::opt_reserved) |=> $stable(opt_ff) && !single_ff
    ) else $error("reserved strobe option changed state");

    single_once_a: assert property (
        @(posedge clk) disable iff (!nrst)
        single_ff |=> !single_ff && opt_ff == dac_update_pkg::opt_latched
    ) else $error("single update pulse longer than one cycle");

    cont_follow_a: assert property (
        @(posedge clk) disable iff (!nrst)
        (opt_ff == dac_update_pkg::opt_continuous && dirty_ff[0] && !fr_ok)
        |=> dac_ff[0] == $past(in_ff[0]) && !dirty_ff[0]
    ) else $error("continuous option did not pass input through");

    latch_hold_a: assert property (
        @(posedge clk) disable iff (!nrst)
        (opt_ff == dac_update_pkg::opt_latched && !strobe_low && !single_ff && !fr_ok)
        |=> $stable(dac_ff[1]) && $stable(act_cfg_ff)
    ) else $error("latched dac register changed");

    skip_clean_a: assert property (
        @(posedge clk) disable iff (!nrst)
        (load_now && !dirty_ff[2] && !fr_ok) |=> $stable(dac_ff[2])
    ) else $error("unchanged channel was reloaded");

    write_input_a: assert property (
        @(posedge clk) disable iff (!nrst)
        (fr_ok && !is_ctrl && word[14:12] == 3'h3)
        |=> in_ff[3] == $past(word[dac_update_pkg::DATA_HI -: DATA_W]) && dirty_ff[3]
    ) else $error("data frame did not load its input register");

    pd_apply_a: assert property (
        @(posedge clk) disable iff (!nrst)
        do_pd |=> pwrdn == $past(word[CH_N-1:0])
    ) else $error("power-down bits not applied");

    data_reset_a: assert property (
        @(posedge clk) disable iff (!nrst)
        (do_reset && !do_full) |=> in_ff[4] == '0 && dac_ff[4] == '0 && $stable(opt_ff)
            && $stable(pwrdn_ff)
    ) else $error("data reset wrong");

    full_reset_a: assert property (
        @(posedge clk) disable iff (!nrst)
        do_full |=> opt_ff == dac_update_pkg::OPT_RESET && pwrdn_ff == dac_update_pkg::PWRDN_RESET
            && act_cfg_ff == dac_update_pkg::REF_CFG_RESET && dac_ff[5] == '0
    ) else $error("full reset left control state");

    supply_override_a: assert property (
        @(posedge clk) disable iff (!nrst)
        (act_cfg_ff.supply & (act_cfg_ff.gain | act_cfg_ff.buffered)) == 2'h0
    ) else $error("supply reference with gain or buffer active");

    sync_update_a: assert property (
        @(posedge clk) disable iff (!nrst)
        (fr_ok && !is_ctrl && word[14:12] == 3'h7 && opt_ff == dac_update_pkg::opt_continuous)
        |-> ##2 dac_ff[7] == $past(word[dac_update_pkg::DATA_HI -: DATA_W], 2)
    ) else $error("continuous write did not reach the dac register");

    pin_copy_a: assert property (
        @(posedge clk) disable iff (!nrst)
        (strobe_low && dirty_ff[6] && !fr_ok) |=> dac_ff[6] == $past(in_ff[6]) && !dirty_ff[6]
    ) else $error("low strobe pin did not copy a written channel");

    // one wait state, and pready never stands for two cycles
    apb_one_wait_a: assert property (
        @(posedge clk) disable iff (!nrst)
        (psel && penable && !pready_ff) |=> pready_ff ##1 !pready_ff
    ) else $error("apb answer not exactly one wait state");
endmodule : dac_update_ctrl

// ===== tb/serial_host_model.sv
// behavioural serial host: frames of up to 16 bits and a load strobe pin
module serial_host_model (
    input wire logic clk,
    output dac_update_pkg::serial_pins_type pins
);
    timeunit 1ns;
    timeprecision 100ps;

    // idle: clock high and still, select and strobe deasserted
    initial begin
        pins = 4'hD;
    end

    // sclk period is 8 clk (32 ns), data changes only while sclk is high
    task automatic send(input logic [15:0] word, input int edges);
        int i;
        @(posedge clk);
        pins.sync_n <= 1'b0;
        repeat (4) @(posedge clk);
        for (i = 15; i > 15 - edges; i--) begin
            pins.din <= word[i];
            repeat (4) @(posedge clk);
            pins.sclk <= 1'b0;
            repeat (4) @(posedge clk);
            pins.sclk <= 1'b1;
        end
        repeat (4) @(posedge clk);
        pins.sync_n <= 1'b1;
        pins.din <= ~pins.din; // released line must not keep the last bit
        repeat (12) @(posedge clk);
    endtask : send

    // short low pulse on the load strobe pin
    task automatic strobe();
        pins.strobe_n <= 1'b0;
        repeat (4) @(posedge clk);
        pins.strobe_n <= 1'b1;
        repeat (8) @(posedge clk);
    endtask : strobe

    // strobe pin held low across the whole last write
    task automatic send_strobed(input logic [15:0] word);
        pins.strobe_n <= 1'b0;
        send(word, 16);
        pins.strobe_n <= 1'b1;
    endtask : send_strobed
endmodule : serial_host_model

// ===== tb/octal_dac_update_control_tb_top.sv
module octal_dac_update_control_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {
        logic [15:0] word;
        logic [2:0] ch;
        logic [11:0] code;
    } row_type;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0][11:0] dac_code;
    dac_update_pkg::ref_cfg_type ref_cfg;
    dac_update_pkg::serial_pins_type pins;
    logic [7:0] pwrdn;
    logic iface_on;
    logic [31:0] rd;
    logic er;
    int miscompares = 0;
    int total_checks = 0;
    int cycles = 0;
    int k;
    // one data write per channel, all eight addresses
    row_type rows [8] = '{'{16'h0FFF, 3'h0, 12'hFFF}, '{16'h1001, 3'h1, 12'h001},
        '{16'h2800, 3'h2, 12'h800}, '{16'h37FF, 3'h3, 12'h7FF}, '{16'h4555, 3'h4, 12'h555},
        '{16'h5AAA, 3'h5, 12'hAAA}, '{16'h60F0, 3'h6, 12'h0F0}, '{16'h7F0F, 3'h7, 12'hF0F}};

    dac_update_ctrl u_dut (.clk(clk), .nrst(nrst), .pins(pins), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .dac_code(dac_code),
        .ref_cfg(ref_cfg), .pwrdn(pwrdn), .iface_on(iface_on));
    serial_host_model u_host (.clk(clk), .pins(pins));

    initial begin
        forever #2 clk = ~clk;
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : test_done

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    // one apb transfer; waits for pready, takes data at that edge, then releases
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        // no wait count of its own: only the hang guard ends a lost transfer
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    // hang guard, tests need about 4700 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            miscompares++;
            test_done();
        end
    end

    initial begin
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        check({pwrdn, ref_cfg, iface_on, dac_code[0]}, 0, "reset outputs");
        apb(1'b0, dac_update_pkg::ADDR_STATUS, 0);
        check(rd[1:0], 2'b01, "power-on option");
        apb(1'b0, 8'hFC, 0);
        check(er, 1'b1, "unmapped error");
        // latched: new input value must not reach the dac register
        u_host.send(16'h0123, 16);
        check(dac_code[0], 0, "latched hold");
        apb(1'b0, 8'h40, 0);
        check(rd, 32'h123, "input reg");
        apb(1'b0, dac_update_pkg::ADDR_STATUS, 0);
        check(rd[31:24], 8'h01, "written flag");
        u_host.strobe();
        check(dac_code[0], 12'h123, "pin copy");
        apb(1'b0, dac_update_pkg::ADDR_STATUS, 0);
        check(rd[31:24], 8'h00, "flag cleared");
        // single update then back to latched
        u_host.send(16'h1456, 16);
        u_host.send(16'hA002, 16);
        check(dac_code[1], 12'h456, "single pulse");
        apb(1'b0, dac_update_pkg::ADDR_STATUS, 0);
        check(rd[1:0], 2'b01, "after single");
        // reference settings wait for a load event
        u_host.send(16'h803C, 16);
        check(ref_cfg, 6'h00, "cfg pending");
        u_host.strobe();
        check(ref_cfg, 6'h3C, "cfg moved");
        u_host.send(16'h803D, 16);
        u_host.strobe();
        check(ref_cfg, 6'h29, "supply override");
        u_host.send(16'hC0A5, 16);
        check(pwrdn, 8'hA5, "power-down");
        u_host.send(16'hA003, 16);
        apb(1'b0, dac_update_pkg::ADDR_STATUS, 0);
        check(rd[1:0], 2'b01, "reserved option");
        // link disabled drops frames
        apb(1'b1, dac_update_pkg::ADDR_CTRL, 0);
        u_host.send(16'h1777, 16);
        apb(1'b0, 8'h44, 0);
        check(rd, 32'h456, "link off");
        apb(1'b1, dac_update_pkg::ADDR_CTRL, 1);
        apb(1'b0, dac_update_pkg::ADDR_CTRL, 0);
        check(rd, 32'h1, "ctrl readback");
        u_host.send(16'hA000, 16);
        apb(1'b0, dac_update_pkg::ADDR_STATUS, 0);
        check(rd[1:0], 2'b00, "continuous set");
        u_host.send(16'hA003, 16);
        apb(1'b0, dac_update_pkg::ADDR_STATUS, 0);
        check(rd[1:0], 2'b00, "reserved ignored");
        for (k = 0; k < 8; k++) begin
            u_host.send(rows[k].word, 16);
            check(dac_code[rows[k].ch], rows[k].code, "row write");
        end
        // early select rise leaves everything alone
        u_host.send(16'h7123, 10);
        apb(1'b0, 8'h5C, 0);
        check(rd, 32'hF0F, "aborted frame");
        fork
            u_host.send(16'h8000, 16);
            begin
                repeat (40) @(posedge clk);
                check(iface_on, 1'b1, "front end on");
            end
        join
        check(iface_on, 1'b0, "front end off");
        u_host.send(16'hE000, 16);
        check({31'h0, |dac_code}, 0, "data reset");
        check(pwrdn, 8'hA5, "control kept");
        apb(1'b0, 8'h5C, 0);
        check(rd, 0, "input cleared");
        u_host.send(16'hF000, 16);
        check({pwrdn, ref_cfg}, 0, "full reset");
        apb(1'b0, dac_update_pkg::ADDR_STATUS, 0);
        check(rd[1:0], 2'b01, "option restored");
        // seven writes wait, the eighth with the pin low moves them all
        for (k = 0; k < 7; k++) begin
            u_host.send(rows[k].word, 16);
        end
        check({31'h0, |dac_code}, 0, "latched hold all");
        u_host.send_strobed(rows[7].word);
        for (k = 0; k < 8; k++) begin
            check(dac_code[rows[k].ch], rows[k].code, "joint update");
        end
        // reset in mid-run brings outputs and control back to power-on values
        u_host.send(16'hC0FF, 16);
        apb(1'b1, dac_update_pkg::ADDR_CTRL, 0);
        nrst <= 1'b0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        check({pwrdn, ref_cfg, iface_on, dac_code[0]}, 0, "mid-run reset");
        apb(1'b0, dac_update_pkg::ADDR_STATUS, 0);
        check(rd[1:0], 2'b01, "option after reset");
        apb(1'b0, dac_update_pkg::ADDR_CTRL, 0);
        check(rd, 32'h1, "ctrl after reset");
        test_done();
    end
endmodule : octal_dac_update_control_tb_top
